// ---- logic/host_port_params.svh ----
// offsets, field positions, reset values and timing counts of the host port
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH
`define DATA_WIDTH      8
`define ADDR_WIDTH      4
`define CHANNELS        16
`define REG_COUNT       24
`define IDX_WIDTH       5
// direct addresses, index equals address
`define ADDR_INDIRECT   4'h0
`define ADDR_PINS       4'h1
`define ADDR_PEND_LO    4'h2
`define ADDR_PEND_HI    4'h3
`define ADDR_SERV_LO    4'h4
`define ADDR_SERV_HI    4'h5
`define ADDR_MASK_LO    4'h6
`define ADDR_MASK_HI    4'h7
`define ADDR_PTR_VEC    4'h8
`define ADDR_TMR_AB_CTL 4'h9
`define ADDR_TMR_B_DATA 4'ha
`define ADDR_TMR_A_DATA 4'hb
`define ADDR_SER_CTL    4'hc
`define ADDR_RX_STAT    4'hd
`define ADDR_TX_STAT    4'he
`define ADDR_SER_DATA   4'hf
// indirect registers sit at index 16 plus their pointer value
`define IDX_INDIRECT    5'h10
`define IND_SYNC_CHAR   3'h0
`define IND_TMR_D_DATA  3'h1
`define IND_TMR_C_DATA  3'h2
`define IND_EDGE_POL    3'h3
`define IND_ENA_LO      3'h4
`define IND_ENA_HI      3'h5
`define IND_PIN_DIR     3'h6
`define IND_TMR_CD_CTL  3'h7
// pointer_vector fields
`define PV_VEC_HI       7
`define PV_VEC_LO       5
`define PV_SERVICE_BIT  3
`define PV_INDEX_HI     2
`define PV_INDEX_LO     0
// entries held in the plain array, and those untouched by reset
`define PLAIN_MASK      24'hffffc2
`define KEEP_ON_RESET   24'h068c00
`define REG_RESET       8'h00
// return-from-interrupt opcode pair
`define RETI_FIRST      8'hed
`define RETI_SECOND     8'h4d
// synchroniser depth
`define SYNC_STAGES     2
`endif

// ---- logic/host_port_pkg.sv ----
// types shared by the host port design
`default_nettype none
package host_port_pkg;
    typedef enum logic [1:0]
    {
        RETI_IDLE   = 2'b00,
        RETI_SAW_ED = 2'b01
    } reti_state_type;
endpackage
`default_nettype wire

// ---- logic/host_bus_regfile_vector_port.sv ----
// host bus register file, indirect window and interrupt vector port
//
// Functional notes
// - reset clears control registers, not timer or serial data; pins become inputs.
// - reads occur only while chip select and read strobe are both low.
// - data bus is released except during a read or acknowledge.
// - write data is stored after chip select or write strobe rises.
// - register access follows bus strobes, not any system clock phase.
// - four address lines pick one of sixteen direct registers.
// - direct map: window, pins, pending, in-service, mask, pointer, timers, serial.
// - pointer index selects one of eight indirect registers via address zero.
// - indirect accesses leave the pointer index unchanged.
// - indirect map: sync, timer D, timer C, edge, enables, direction, timer C/D.
// - acknowledge drives a vector unique to the responding channel.
// - vector bits 7 to 5 come from the pointer top bits.
// - vector bit 0 is always zero.
// - vector bits 4 to 1 carry the channel number, higher is higher priority.
// - io request plus first cycle strobe, both low, means acknowledge.
// - interrupt request is an active-low open-drain output.
// - vector handover clears pending and optionally sets in-service.
// - return-from-interrupt opcode pair clears the in-service bit.
`timescale 1ns/1ns
`default_nettype none
`include "host_port_params.svh"
module host_bus_regfile_vector_port
#(
    parameter int CHANNELS = `CHANNELS
)
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        ce_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [3:0]  addr,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe_n,
    input  wire logic        io_request_n,
    input  wire logic        first_cycle_n,
    input  wire logic        chain_enable_in,
    output logic             chain_enable_out,
    output logic             int_out,
    output logic             int_oe_n,
    input  wire logic [15:0] channel_request,
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe_n,
    output logic             reg_write_pulse,
    output logic      [4:0]  reg_write_index,
    output logic      [7:0]  reg_write_data
);

    localparam int BUS_BITS = 6 + `ADDR_WIDTH + `DATA_WIDTH + 8;

    if (CHANNELS != 16)
    begin : g_bad_channels
        $error("vector format serves exactly sixteen channels");
    end

    // pins come from the processor's own timing, so every one is resynchronised
    logic [BUS_BITS-1:0] bus_s1;
    logic [BUS_BITS-1:0] bus_s2;
    logic                ce_s;
    logic                rd_s;
    logic                wr_s;
    logic                io_request_n_s;
    logic                m1_s;
    logic                chain_in_s;
    logic [3:0]          addr_s;
    logic [7:0]          data_s;
    logic [7:0]          pins_s;

    always_ff @(posedge core_clk)
    begin
        bus_s1 <= {ce_n, rd_n, wr_n, io_request_n, first_cycle_n, chain_enable_in,
                   addr, data_in, pin_in};
        bus_s2 <= bus_s1;
    end

    assign {ce_s, rd_s, wr_s, io_request_n_s, m1_s, chain_in_s, addr_s, data_s, pins_s} = bus_s2;

    // strobe decode
    logic rd_act;
    logic wr_act;
    logic wr_act_d;
    logic ack_act;
    logic ack_act_d;
    logic fetch_act;
    logic fetch_act_d;

    assign rd_act    = !ce_s && !rd_s;
    assign wr_act    = !ce_s && !wr_s;
    assign ack_act   = !io_request_n_s && !m1_s;
    assign fetch_act = !m1_s && io_request_n_s && !rd_s;

    // register storage
    logic [7:0]  regs_q [0:`REG_COUNT-1];
    logic [15:0] pend_reg;
    logic [15:0] pend_next;
    logic [15:0] serv_reg;
    logic [15:0] serv_next;
    logic [2:0]  ind_index;
    logic        wr_end;
    logic [3:0]  wr_addr_reg;
    logic [7:0]  wr_data_reg;
    logic [4:0]  wr_index;

    assign ind_index = regs_q[`ADDR_PTR_VEC][`PV_INDEX_HI:`PV_INDEX_LO];

    function automatic logic [4:0] sel_index(input logic [3:0] a, input logic [2:0] p);
        logic [4:0] r;
        r = {1'b0, a};
        if (a == `ADDR_INDIRECT)
        begin
            r = `IDX_INDIRECT | {2'b00, p};
        end
        return r;
    endfunction

    // address and data are held by the master until the access ends
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wr_act_d    <= 1'b0;
            wr_addr_reg <= 4'h0;
            wr_data_reg <= 8'h00;
        end
        else
        begin
            wr_act_d <= wr_act;
            if (wr_act)
            begin
                wr_addr_reg <= addr_s;
                wr_data_reg <= data_s;
            end
        end
    end

    assign wr_end   = wr_act_d && !wr_act;
    assign wr_index = sel_index(wr_addr_reg, ind_index);

    // plain registers, one flop group per entry
    for (genvar i = 0; i < `REG_COUNT; i++)
    begin : g_regs
        localparam logic [23:0] PLAIN = `PLAIN_MASK;
        localparam logic [23:0] KEEP  = `KEEP_ON_RESET;
        if (PLAIN[i] && KEEP[i])
        begin : g_data
            // data registers keep their contents through reset
            always_ff @(posedge core_clk)
            begin
                if (wr_end && wr_index == 5'(i))
                begin
                    regs_q[i] <= wr_data_reg;
                end
            end
        end
        else if (PLAIN[i])
        begin : g_ctrl
            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                begin
                    regs_q[i] <= `REG_RESET;
                end
                else if (wr_end && wr_index == 5'(i))
                begin
                    regs_q[i] <= wr_data_reg;
                end
            end
        end
        else
        begin : g_none
            assign regs_q[i] = `REG_RESET;
        end
    end

    // interrupt channel bookkeeping
    logic [15:0] enable_bits;
    logic [15:0] mask_bits;
    logic [15:0] live;
    logic        any_live;
    logic [3:0]  top_live;
    logic [3:0]  top_serv;
    logic        any_serv;
    logic [3:0]  ack_chan_reg;
    logic        ack_drive_reg;
    logic        ack_take;
    logic        reti_done;

    assign enable_bits = {regs_q[`IDX_INDIRECT | 5'(`IND_ENA_HI)],
                          regs_q[`IDX_INDIRECT | 5'(`IND_ENA_LO)]};
    assign mask_bits   = {regs_q[`ADDR_MASK_HI], regs_q[`ADDR_MASK_LO]};
    assign live        = pend_reg & mask_bits;
    assign any_live    = |live;
    assign any_serv    = |serv_reg;

    function automatic logic [3:0] top_bit(input logic [15:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int k = 0; k < 16; k++)
        begin
            if (v[k])
            begin
                r = 4'(k);
            end
        end
        return r;
    endfunction

    assign top_live = top_bit(live);
    assign top_serv = top_bit(serv_reg);

    // acknowledge is taken once, on its leading edge
    assign ack_take = ack_act && !ack_act_d && chain_in_s && any_live;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ack_act_d     <= 1'b0;
            ack_drive_reg <= 1'b0;
            ack_chan_reg  <= 4'h0;
        end
        else
        begin
            ack_act_d <= ack_act;
            if (ack_take)
            begin
                ack_drive_reg <= 1'b1;
                ack_chan_reg  <= top_live;
            end
            else if (!ack_act)
            begin
                ack_drive_reg <= 1'b0;
            end
        end
    end

    always_comb
    begin
        pend_next = pend_reg;
        serv_next = serv_reg;
        if (wr_end && wr_index == 5'(`ADDR_PEND_LO))
        begin
            pend_next[7:0] = pend_reg[7:0] & wr_data_reg;
        end
        if (wr_end && wr_index == 5'(`ADDR_PEND_HI))
        begin
            pend_next[15:8] = pend_reg[15:8] & wr_data_reg;
        end
        if (wr_end && wr_index == 5'(`ADDR_SERV_LO))
        begin
            serv_next[7:0] = serv_reg[7:0] & wr_data_reg;
        end
        if (wr_end && wr_index == 5'(`ADDR_SERV_HI))
        begin
            serv_next[15:8] = serv_reg[15:8] & wr_data_reg;
        end
        if (reti_done && any_serv)
        begin
            serv_next[top_serv] = 1'b0;
        end
        if (ack_take)
        begin
            pend_next[top_live] = 1'b0;
            if (regs_q[`ADDR_PTR_VEC][`PV_SERVICE_BIT])
            begin
                serv_next[top_live] = 1'b1;
            end
        end
        // a new request wins over a clear in the same cycle
        pend_next = pend_next | (channel_request & enable_bits);
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pend_reg <= 16'h0000;
            serv_reg <= 16'h0000;
        end
        else
        begin
            pend_reg <= pend_next;
            serv_reg <= serv_next;
        end
    end

    // return-from-interrupt watch on opcode fetches
    host_port_pkg::reti_state_type reti_reg;
    logic [7:0]                    fetch_byte_reg;
    logic                          fetch_end;

    assign fetch_end = fetch_act_d && !fetch_act;
    assign reti_done = fetch_end && reti_reg == host_port_pkg::RETI_SAW_ED
                       && fetch_byte_reg == `RETI_SECOND;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            fetch_act_d    <= 1'b0;
            fetch_byte_reg <= 8'h00;
            reti_reg       <= host_port_pkg::RETI_IDLE;
        end
        else
        begin
            fetch_act_d <= fetch_act;
            if (fetch_act)
            begin
                fetch_byte_reg <= data_s;
            end
            if (fetch_end)
            begin
                case (reti_reg)
                    host_port_pkg::RETI_IDLE:
                    begin
                        if (fetch_byte_reg == `RETI_FIRST)
                        begin
                            reti_reg <= host_port_pkg::RETI_SAW_ED;
                        end
                    end
                    host_port_pkg::RETI_SAW_ED:
                    begin
                        reti_reg <= (fetch_byte_reg == `RETI_FIRST)
                                    ? host_port_pkg::RETI_SAW_ED
                                    : host_port_pkg::RETI_IDLE;
                    end
                    default:
                    begin
                        reti_reg <= host_port_pkg::RETI_IDLE;
                    end
                endcase
            end
        end
    end

    // read multiplexer
    logic [4:0] rd_index;
    logic [7:0] rd_value;
    logic [7:0] pin_dir;

    assign rd_index = sel_index(addr_s, ind_index);
    assign pin_dir  = regs_q[`IDX_INDIRECT | 5'(`IND_PIN_DIR)];

    always_comb
    begin
        case (rd_index)
            5'(`ADDR_PINS):
            begin
                rd_value = (regs_q[`ADDR_PINS] & pin_dir) | (pins_s & ~pin_dir);
            end
            5'(`ADDR_PEND_LO):
            begin
                rd_value = pend_reg[7:0];
            end
            5'(`ADDR_PEND_HI):
            begin
                rd_value = pend_reg[15:8];
            end
            5'(`ADDR_SERV_LO):
            begin
                rd_value = serv_reg[7:0];
            end
            5'(`ADDR_SERV_HI):
            begin
                rd_value = serv_reg[15:8];
            end
            default:
            begin
                rd_value = regs_q[rd_index];
            end
        endcase
    end

    // data bus driver; vector wins since a read cannot overlap an acknowledge
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            data_out  <= 8'h00;
            data_oe_n <= 1'b1;
        end
        else if (ack_drive_reg)
        begin
            data_out  <= {regs_q[`ADDR_PTR_VEC][`PV_VEC_HI:`PV_VEC_LO],
                          ack_chan_reg,
                          1'b0};
            data_oe_n <= 1'b0;
        end
        else if (rd_act)
        begin
            data_out  <= rd_value;
            data_oe_n <= 1'b0;
        end
        else
        begin
            data_oe_n <= 1'b1;
        end
    end

    // request line, chain and pin outputs
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            int_out          <= 1'b0;
            int_oe_n         <= 1'b1;
            chain_enable_out <= 1'b0;
            pin_out          <= 8'h00;
            pin_oe_n         <= 8'hff;
        end
        else
        begin
            int_out          <= 1'b0;
            int_oe_n         <= !any_live;
            chain_enable_out <= chain_in_s && !any_live && !any_serv;
            pin_out          <= regs_q[`ADDR_PINS];
            pin_oe_n         <= ~pin_dir;
        end
    end

    // write mirror for the timer and serial blocks
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            reg_write_pulse <= 1'b0;
            reg_write_index <= 5'h00;
            reg_write_data  <= 8'h00;
        end
        else
        begin
            reg_write_pulse <= wr_end;
            if (wr_end)
            begin
                reg_write_index <= wr_index;
                reg_write_data  <= wr_data_reg;
            end
        end
    end

endmodule
`default_nettype wire

// ---- verif/host_port_asserts.sv ----
// concurrent checks on the host port pins
`timescale 1ns/1ns
`default_nettype none
module host_port_asserts
#(
    parameter int CHANNELS = 16
)
(
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       ce_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic [3:0] addr,
    input wire logic       io_request_n,
    input wire logic       first_cycle_n,
    input wire logic       chain_enable_in,
    input wire logic       chain_enable_out,
    input wire logic [7:0] data_out,
    input wire logic       data_oe_n,
    input wire logic       int_out,
    input wire logic       int_oe_n,
    input wire logic [7:0] pin_oe_n,
    input wire logic       reg_write_pulse,
    input wire logic [4:0] reg_write_index
);
    default clocking cb @(posedge core_clk);
    endclocking

    a_bus_idle: assert property (disable iff (!rst_n)
        ((ce_n || rd_n) && io_request_n)[*6] |-> data_oe_n)
        else $error("data bus driven while idle");
    a_read_answer: assert property (disable iff (!rst_n)
        (!ce_n && !rd_n)[*4] |-> !data_oe_n)
        else $error("read not answered in time");
    a_vec_even: assert property (disable iff (!rst_n)
        !data_oe_n && !io_request_n && !first_cycle_n
        |-> !data_out[0] && data_out[4:1] <= CHANNELS - 1)
        else $error("vector low bit not zero");
    a_write_store: assert property (disable iff (!rst_n)
        $rose(ce_n || wr_n) |-> ##[2:4] reg_write_pulse)
        else $error("write not stored after strobe rise");
    a_write_single: assert property (disable iff (!rst_n)
        reg_write_pulse |=> !reg_write_pulse)
        else $error("write pulse longer than one cycle");
    a_write_addr: assert property (disable iff (!rst_n)
        reg_write_pulse && !reg_write_index[4] |-> reg_write_index[3:0] == $past(addr, 4))
        else $error("write went to wrong direct register");
    a_chain_block: assert property (disable iff (!rst_n)
        (!chain_enable_in)[*4] |-> !chain_enable_out)
        else $error("chain out high without chain in");
    a_ack_refused: assert property (disable iff (!rst_n)
        (ce_n && !chain_enable_in)[*6] |-> data_oe_n)
        else $error("acknowledge answered without chain in");
    a_int_drain: assert property (disable iff (!rst_n)
        int_out == 1'b0)
        else $error("request line driven high");
    // no disable here: the check is about the reset itself
    a_reset_quiet: assert property (
        !rst_n |=> data_oe_n && int_oe_n && pin_oe_n == 8'hff)
        else $error("outputs active after reset");
endmodule

bind host_bus_regfile_vector_port host_port_asserts #(.CHANNELS(CHANNELS)) i_host_port_asserts
(
    .core_clk(core_clk), .rst_n(rst_n), .ce_n(ce_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .io_request_n(io_request_n), .first_cycle_n(first_cycle_n),
    .chain_enable_in(chain_enable_in), .chain_enable_out(chain_enable_out),
    .data_out(data_out), .data_oe_n(data_oe_n), .int_out(int_out), .int_oe_n(int_oe_n),
    .pin_oe_n(pin_oe_n), .reg_write_pulse(reg_write_pulse),
    .reg_write_index(reg_write_index)
);
`default_nettype wire

// ---- verif/host_bus_master.sv ----
// processor bus master model driving the host port
`timescale 1ns/1ns
`default_nettype none
module host_bus_master
(
    input  wire logic       core_clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe_n,
    output var logic        ce_n,
    output var logic        rd_n,
    output var logic        wr_n,
    output var logic [3:0]  addr,
    output var logic        io_request_n,
    output var logic        first_cycle_n,
    output wire logic [7:0] data_in
);
    logic       drive = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] idle  = 8'h5a;

    // released bus shows a changing pattern, never a stale byte
    assign data_in = !data_oe_n ? data_out : (drive ? wdata : idle);
    always @(posedge core_clk) idle <= ~data_in;

    initial
    begin
        {ce_n, rd_n, wr_n, io_request_n, first_cycle_n} = 5'h1f;
        addr = 4'h0;
    end

    // kind: 0 write, 1 read, 2 acknowledge, 3 opcode fetch
    task automatic access(input int kind, input logic [3:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic ok);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        drive <= kind == 0 || kind == 3;
        ce_n <= kind > 1;
        rd_n <= kind == 0 || kind == 2;
        wr_n <= kind != 0;
        io_request_n <= kind != 2;
        first_cycle_n <= kind < 2;
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++)
        begin
            @(posedge core_clk);
            ok = (kind == 0 || kind == 3) ? i == 3 : data_oe_n === 1'b0;
        end
        q = data_in;
        {ce_n, rd_n, wr_n, io_request_n, first_cycle_n} <= 5'h1f;
        // data held past the strobe rise, the port samples it late
        repeat (3) @(posedge core_clk);
        drive <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// ---- verif/host_bus_regfile_vector_port_tb_top.sv ----
// self-checking bench for the host port
`timescale 1ns/1ns
`default_nettype none
module host_bus_regfile_vector_port_tb_top;
    logic        core_clk;
    logic        rst_n;
    logic        chain_enable_in;
    logic [15:0] channel_request;
    logic [7:0]  pin_in;
    wire logic        ce_n, rd_n, wr_n, io_request_n, first_cycle_n;
    wire logic [3:0]  addr;
    wire logic [7:0]  data_in, data_out, pin_oe_n;
    wire logic [7:0]  pin_out, reg_write_data;
    wire logic        data_oe_n, chain_enable_out, int_oe_n;
    int          n_errors = 0;
    int          n_compared = 0;

    host_bus_regfile_vector_port i_host_bus_regfile_vector_port
    (
        .core_clk(core_clk), .rst_n(rst_n), .ce_n(ce_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .io_request_n(io_request_n), .first_cycle_n(first_cycle_n),
        .chain_enable_in(chain_enable_in), .chain_enable_out(chain_enable_out),
        .int_out(), .int_oe_n(int_oe_n), .channel_request(channel_request),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .reg_write_pulse(),
        .reg_write_index(), .reg_write_data(reg_write_data)
    );
    host_bus_master i_host_bus_master
    (
        .core_clk(core_clk), .data_out(data_out), .data_oe_n(data_oe_n), .ce_n(ce_n),
        .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .io_request_n(io_request_n),
        .first_cycle_n(first_cycle_n), .data_in(data_in)
    );

    always #5 core_clk = ~core_clk;

    function automatic logic [7:0] vec_of(input logic [7:0] pv, input logic [3:0] ch);
        return {pv[7:5], ch, 1'b0};
    endfunction
    function automatic logic [7:0] ch_bit(input int ch);
        return 8'h01 << ch[2:0];
    endfunction

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp);
        check8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       ok;
        i_host_bus_master.access(0, a, d, q, ok);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic       ok;
        i_host_bus_master.access(1, a, 8'h00, q, ok);
        check1(ok, 1'b1);
        check8(q, exp);
    endtask
    task automatic ack(output logic [7:0] q, output logic ok);
        i_host_bus_master.access(2, 4'h0, 8'h00, q, ok);
    endtask
    task automatic reti();
        logic [7:0] q;
        logic       ok;
        i_host_bus_master.access(3, 4'h0, 8'hed, q, ok);
        i_host_bus_master.access(3, 4'h0, 8'h4d, q, ok);
    endtask
    task automatic pulse(input logic [15:0] m);
        @(posedge core_clk);
        channel_request <= m;
        @(posedge core_clk);
        channel_request <= 16'h0000;
        repeat (4) @(posedge core_clk);
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        give_verdict();
    end

    initial
    begin
        logic [7:0] v [16];
        logic [7:0] q;
        logic [7:0] pv;
        logic       ok;
        core_clk = 1'b0;
        rst_n = 1'b0;
        chain_enable_in = 1'b1;
        channel_request = 16'h0000;
        pin_in = 8'h00;
        void'($urandom(24333));
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        pin_in <= 8'($urandom());
        @(posedge core_clk);
        check1(int_oe_n, 1'b1);
        check8(pin_oe_n, 8'hff);
        for (int a = 2; a < 15; a++)
            if (a != 10 && a != 11)
                rd(4'(a), 8'h00);
        for (int a = 6; a < 16; a++)
        begin
            v[a] = 8'($urandom());
            if (a != 8)
                wr(4'(a), v[a]);
        end
        for (int a = 6; a < 16; a++)
            if (a != 8)
                rd(4'(a), v[a]);
        for (int k = 0; k < 8; k++)
        begin
            v[k] = 8'($urandom());
            wr(4'h8, 8'(k));
            wr(4'h0, v[k]);
        end
        for (int k = 0; k < 8; k++)
        begin
            wr(4'h8, 8'(k));
            rd(4'h0, v[k]);
            rd(4'h0, v[k]);
            rd(4'h8, 8'(k));
        end
        check8(pin_oe_n, ~v[6]);
        q = 8'($urandom());
        wr(4'h1, q);
        check8(reg_write_data, q);
        check8(pin_out, q);
        rd(4'h1, (q & v[6]) | (pin_in & ~v[6]));
        wr(4'h8, 8'h04);
        wr(4'h0, 8'hff);
        wr(4'h8, 8'h05);
        wr(4'h0, 8'hff);
        wr(4'h6, 8'hff);
        wr(4'h7, 8'hff);
        for (int ch = 0; ch < 16; ch++)
        begin
            pv = {3'($urandom()), 5'h08};
            wr(4'h8, pv);
            pulse(16'h0001 << ch);
            check1(int_oe_n, 1'b0);
            check1(chain_enable_out, 1'b0);
            rd(4'(2 + ch / 8), ch_bit(ch));
            ack(q, ok);
            check1(ok, 1'b1);
            check8(q, vec_of(pv, 4'(ch)));
            rd(4'(2 + ch / 8), 8'h00);
            rd(4'(4 + ch / 8), ch_bit(ch));
            reti();
            rd(4'(4 + ch / 8), 8'h00);
            check1(chain_enable_out, 1'b1);
        end
        // in-service off so neither acknowledge leaves a service bit set
        pv = 8'he0;
        wr(4'h8, pv);
        pulse(16'h8001);
        ack(q, ok);
        check8(q, vec_of(pv, 4'hf));
        ack(q, ok);
        check8(q, vec_of(pv, 4'h0));
        rd(4'h5, 8'h00);
        wr(4'h6, 8'h00);
        pulse(16'h0004);
        check1(int_oe_n, 1'b1);
        check1(chain_enable_out, 1'b1);
        @(posedge core_clk);
        chain_enable_in <= 1'b0;
        // two sync stages plus the output flop
        repeat (4) @(posedge core_clk);
        check1(chain_enable_out, 1'b0);
        wr(4'h6, 8'hff);
        ack(q, ok);
        check1(ok, 1'b0);
        @(posedge core_clk);
        chain_enable_in <= 1'b1;
        repeat (4) @(posedge core_clk);
        ack(q, ok);
        check8(q, vec_of(pv, 4'h2));
        pulse(16'h0200);
        wr(4'h3, 8'hfd);
        rd(4'h3, 8'h00);
        check1(int_oe_n, 1'b1);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        check8(pin_oe_n, 8'hff);
        check8(pin_out, 8'h00);
        rd(4'h8, 8'h00);
        rd(4'hb, v[11]);
        give_verdict();
    end
endmodule
`default_nettype wire
